/* logic/bel_defs.svh */
// Offsets, field positions, codes and counts of the bus error logger.
// Assumes a 32-bit AXI4-Lite register window with 12-bit byte addresses.
`ifndef BEL_DEFS_SVH
`define BEL_DEFS_SVH

`define BEL_ADDR_W 12
`define BEL_OFF_STAT_LO 12'h000
`define BEL_OFF_STAT_HI 12'h004
`define BEL_OFF_IRQ_STAT 12'h008
`define BEL_OFF_IRQ_MASK 12'h00C
`define BEL_OFF_WDOG 12'h010
`define BEL_OFF_CTRL 12'h014

`define BEL_RESP_OKAY 2'h0
`define BEL_RESP_SLVERR 2'h2

`define BEL_CODE_NONE 16'h0000
`define BEL_CODE_INTERNAL 16'h0400
`define BEL_CODE_BUS 16'h0E0F

`define BEL_MSE_REQ_PAR 0
`define BEL_MSE_HARD_FAIL 4
`define BEL_MSE_RESP_PAR 5
`define BEL_MSE_DATA_PAR 6

`define BEL_STATUS_RESET 64'h0000_0000_0000_0000
`define BEL_STATUS_WMASK 64'hFFFF_8C40_0071_FFFF
`define BEL_STATUS_WMASK_LO 32'h0071_FFFF
`define BEL_STATUS_WMASK_HI 32'hFFFF_8C40

`define BEL_PRESCALE_W 8
`define BEL_PRESCALE_DIV 8'h80
`define BEL_WDOG_W 23
`define BEL_COUNT_W 10

`define BEL_RATIO_RESET 2'h0
`define BEL_IRQ_W 5
`define BEL_IRQ_TIMEOUT 0
`define BEL_IRQ_HARD 1
`define BEL_IRQ_INTERNAL 2
`define BEL_IRQ_PARITY 3
`define BEL_IRQ_CORR 4
`define BEL_IRQ_RESET 5'h00

`endif

/* logic/bel_logger.sv */
// Error status logger for the system front bus and the retire watchdog,
// with an AXI4-Lite register window and one level interrupt.
// Assumes error inputs are synchronous to CLOCK, one cycle per event.
//
// How it works
// [RULE1] Bus clock ticks every 2, 3 or 4 clocks; prescaler divides by 128.
// [RULE2] Each prescaler carry adds exactly one to the retire watchdog.
// [RULE3] Timeout flag sticks; later errors never replace the logged error.
// [RULE4] Hard error response on our transaction sets bit 42, protected.
// [RULE5] Internal failure drives the pin and sets bit 43, protected.
// [RULE6] Internal errors log type code 0x0400 in bits 15:0.
// [RULE7] Bus and interconnect errors log type code 0x0E0F.
// [RULE8] Reserved bus type encodings are never logged.
// [RULE9] Bits 15:0 hold only the internal or bus code, or zero.
// [RULE10] Bits 31:16 carry detail for the logged code.
// [RULE11] Request phase parity error sets detail bit 16.
// [RULE12] Hard failure response sets detail bit 20.
// [RULE13] Response field parity error sets detail bit 21.
// [RULE14] Inbound data parity error sets detail bit 22.
// [RULE15] Correctable events counted in the other-information field.
// [RULE16] Bits 63:57 are the validity indicators.
// [RULE17] Watchdog is 23 bits; carry out of its top bit is a timeout.
// [RULE18] Watchdog clears on retire, exception, reset or its own bus init.
// [RULE19] Reserved status bits are never set.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bel_defs.svh"

module bel_logger (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // AXI4-Lite write address and data
    input wire logic [`BEL_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [`BEL_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Core and bus events
    input wire logic INSTR_RETIRE,
    input wire logic CORE_EXCEPTION,
    input wire bel_pkg::bel_err_t ERR_EVENTS,
    // Outputs to the system
    output logic INTERNAL_FAILURE_PIN,
    output logic BUS_INIT_EVENT,
    output logic IRQ
);

    bel_pkg::bel_status_t status;
    bel_pkg::bel_status_t next_status;
    bel_pkg::bel_ratio_t ratio;
    logic [`BEL_IRQ_W-1:0] irq_stat;
    logic [`BEL_IRQ_W-1:0] irq_mask;
    logic [`BEL_IRQ_W-1:0] irq_set;
    logic [1:0] bus_div;
    logic [1:0] bus_div_max;
    logic bus_tick;
    logic [`BEL_PRESCALE_W-1:0] prescale;
    logic pre_carry;
    logic [`BEL_WDOG_W-1:0] wdog;
    logic wdog_clear;
    logic ev_timeout;
    logic ev_internal;
    logic ev_bus;
    logic protect;

    // AXI write side holding registers
    logic aw_held;
    logic w_held;
    logic [`BEL_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic [31:0] be_mask;
    logic wr_lo;
    logic wr_hi;
    logic wr_map;

    // Bus clock model and prescaler
    always_comb begin
        case (ratio)
            bel_pkg::BEL_RATIO_2: bus_div_max = 2'd1;
            bel_pkg::BEL_RATIO_3: bus_div_max = 2'd2;
            default: bus_div_max = 2'd3;
        endcase
    end

    assign bus_tick = (bus_div == bus_div_max); // RULE1

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            bus_div <= 2'd0;
        end else if (bus_tick) begin
            bus_div <= 2'd0;
        end else begin
            bus_div <= bus_div + 2'd1;
        end
    end

    // Count runs 0..127; the carry marks the wrap
    assign pre_carry = bus_tick &&
        (prescale == (`BEL_PRESCALE_DIV - 8'h01)); // RULE1

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            prescale <= '0;
        end else if (pre_carry) begin
            prescale <= '0; // RULE1
        end else if (bus_tick) begin
            prescale <= prescale + 8'h01;
        end
    end

    // Retire watchdog
    assign wdog_clear = INSTR_RETIRE || CORE_EXCEPTION ||
        BUS_INIT_EVENT; // RULE18
    assign ev_timeout = pre_carry && !wdog_clear && (&wdog); // RULE17

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            wdog <= '0; // RULE18
        end else if (wdog_clear) begin
            wdog <= '0; // RULE18
        end else if (pre_carry) begin
            wdog <= wdog + 23'h1; // RULE2
        end
    end

    // Timeout starts a bus init, which also clears the watchdog
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            BUS_INIT_EVENT <= 1'b0;
        end else begin
            BUS_INIT_EVENT <= ev_timeout; // RULE17
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            INTERNAL_FAILURE_PIN <= 1'b0;
        end else begin
            INTERNAL_FAILURE_PIN <= ERR_EVENTS.internal_fail; // RULE5
        end
    end

    // Error logging
    assign ev_internal = ev_timeout || ERR_EVENTS.internal_fail;
    assign ev_bus = ERR_EVENTS.req_parity || ERR_EVENTS.resp_parity ||
        ERR_EVENTS.data_parity || ERR_EVENTS.hard_resp;
    assign protect = status.timeout_flag || status.hard_flag ||
        status.internal_flag; // RULE3

    always_comb begin
        next_status = status;
        // Software write first, so that hardware events win over it
        if (wr_lo) begin
            next_status[31:0] = (status[31:0] &
                ~(be_mask & `BEL_STATUS_WMASK_LO)) |
                (wr_data & be_mask & `BEL_STATUS_WMASK_LO); // RULE19
        end
        if (wr_hi) begin
            next_status[63:32] = (status[63:32] &
                ~(be_mask & `BEL_STATUS_WMASK_HI)) |
                (wr_data & be_mask & `BEL_STATUS_WMASK_HI); // RULE19
        end
        // A written code that is not a defined one is dropped
        if (next_status.code != `BEL_CODE_NONE &&
            next_status.code != `BEL_CODE_INTERNAL &&
            next_status.code != `BEL_CODE_BUS) begin
            next_status.code = status.code; // RULE8 RULE9
        end
        if (ev_timeout) begin
            next_status.timeout_flag = 1'b1; // RULE3
        end
        if (ERR_EVENTS.hard_resp) begin
            next_status.hard_flag = 1'b1; // RULE4
        end
        if (ERR_EVENTS.internal_fail) begin
            next_status.internal_flag = 1'b1; // RULE5
        end
        if (ERR_EVENTS.correctable && !(&status.corr_count)) begin
            next_status.corr_count = status.corr_count + 10'h001; // RULE15
        end
        if (ev_internal || ev_bus) begin
            next_status.valid.over = status.valid.val; // RULE16
            next_status.valid.val = 1'b1; // RULE16
            next_status.valid.uc = 1'b1;
            next_status.valid.en = 1'b1;
        end
        if (!protect && ev_internal) begin
            next_status.code = `BEL_CODE_INTERNAL; // RULE6
            next_status.mse = 16'h0000; // RULE10
            next_status.valid.pcc = 1'b1;
        end else if (!protect && ev_bus) begin
            next_status.code = `BEL_CODE_BUS; // RULE7
            next_status.mse = 16'h0000; // RULE10
            next_status.mse[`BEL_MSE_REQ_PAR] =
                ERR_EVENTS.req_parity; // RULE11
            next_status.mse[`BEL_MSE_HARD_FAIL] =
                ERR_EVENTS.hard_resp; // RULE12
            next_status.mse[`BEL_MSE_RESP_PAR] =
                ERR_EVENTS.resp_parity; // RULE13
            next_status.mse[`BEL_MSE_DATA_PAR] =
                ERR_EVENTS.data_parity; // RULE14
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            status <= `BEL_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Interrupt status, write one to clear, set wins
    assign irq_set = {ERR_EVENTS.correctable,
        ERR_EVENTS.req_parity | ERR_EVENTS.resp_parity |
        ERR_EVENTS.data_parity,
        ERR_EVENTS.internal_fail, ERR_EVENTS.hard_resp, ev_timeout};

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            irq_stat <= `BEL_IRQ_RESET;
        end else if (wr_fire && wr_addr == `BEL_OFF_IRQ_STAT &&
            wr_strb[0]) begin
            irq_stat <= (irq_stat & ~wr_data[`BEL_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            irq_mask <= `BEL_IRQ_RESET;
        end else if (wr_fire && wr_addr == `BEL_OFF_IRQ_MASK &&
            wr_strb[0]) begin
            irq_mask <= wr_data[`BEL_IRQ_W-1:0];
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ratio <= bel_pkg::bel_ratio_t'(`BEL_RATIO_RESET);
        end else if (wr_fire && wr_addr == `BEL_OFF_CTRL && wr_strb[0]) begin
            ratio <= bel_pkg::bel_ratio_t'(wr_data[1:0]);
        end
    end

    // AXI4-Lite write: address and data taken in either order
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign wr_fire = aw_held && w_held && !BVALID;
    assign be_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
        {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_lo = wr_fire && wr_addr == `BEL_OFF_STAT_LO;
    assign wr_hi = wr_fire && wr_addr == `BEL_OFF_STAT_HI;
    assign wr_map = wr_addr == `BEL_OFF_STAT_LO ||
        wr_addr == `BEL_OFF_STAT_HI || wr_addr == `BEL_OFF_IRQ_STAT ||
        wr_addr == `BEL_OFF_IRQ_MASK || wr_addr == `BEL_OFF_CTRL;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            wr_addr <= {AWADDR[`BEL_ADDR_W-1:2], 2'b00};
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            wr_data <= WDATA;
            wr_strb <= WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            BVALID <= 1'b0;
            BRESP <= `BEL_RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= wr_map ? `BEL_RESP_OKAY : `BEL_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // AXI4-Lite read, one cycle after the address is taken
    assign ARREADY = !RVALID;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `BEL_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= `BEL_RESP_OKAY;
            case ({ARADDR[`BEL_ADDR_W-1:2], 2'b00})
                `BEL_OFF_STAT_LO: RDATA <= status[31:0];
                `BEL_OFF_STAT_HI: RDATA <= status[63:32];
                `BEL_OFF_IRQ_STAT: RDATA <= {27'h0, irq_stat};
                `BEL_OFF_IRQ_MASK: RDATA <= {27'h0, irq_mask};
                `BEL_OFF_WDOG: RDATA <= {9'h000, wdog};
                `BEL_OFF_CTRL: RDATA <= {30'h0, ratio};
                default: begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= `BEL_RESP_SLVERR;
                end
            endcase
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Checks
    sequence s_wdog_full_carry;
        pre_carry && !wdog_clear && (&wdog);
    endsequence

    sequence s_timeout_logged;
        BUS_INIT_EVENT && status.timeout_flag ##1 (wdog == 23'h0);
    endsequence

    AST_PRESCALE_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_B)
        pre_carry |-> bus_tick && prescale == 8'h7F) // RULE1
        else $error("prescaler carry not at count 127");

    AST_WDOG_STEP: assert property (@(posedge CLOCK) disable iff (!RST_B)
        pre_carry && !wdog_clear |=> wdog == $past(wdog) + 23'h1) // RULE2
        else $error("watchdog did not step by one");

    AST_TIMEOUT_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_B)
        status.timeout_flag && !wr_lo && !wr_hi |=> status.timeout_flag &&
        $stable(status.code)) // RULE3
        else $error("timeout flag or logged code changed");

    AST_HARD_SET: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ERR_EVENTS.hard_resp |=> status.hard_flag && status.valid.val) // RULE4
        else $error("hard error not flagged");

    AST_INTERNAL_PIN: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ERR_EVENTS.internal_fail |=> INTERNAL_FAILURE_PIN &&
        status.internal_flag) // RULE5
        else $error("internal failure not reflected");

    AST_INTERNAL_CODE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !protect && ERR_EVENTS.internal_fail |=>
        status.code == 16'h0400 && status.mse == 16'h0000) // RULE6
        else $error("internal error code wrong");

    AST_CODE_LEGAL: assert property (@(posedge CLOCK) disable iff (!RST_B)
        status.code == 16'h0000 || status.code == 16'h0400 ||
        status.code == 16'h0E0F) // RULE9
        else $error("illegal error type code");

    AST_BUS_DETAIL: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !protect && !ev_internal && ERR_EVENTS.req_parity &&
        ERR_EVENTS.data_parity |=> status.code == 16'h0E0F &&
        status.mse == 16'h0041) // RULE11
        else $error("bus error detail wrong");

    AST_RSVD_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (status & ~64'hFFFF_8C40_0071_FFFF) == 64'h0) // RULE19
        else $error("reserved status bit set");

    AST_WDOG_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_B)
        INSTR_RETIRE || CORE_EXCEPTION |=> wdog == 23'h0) // RULE18
        else $error("watchdog not cleared");

    AST_TIMEOUT_SEQ: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_wdog_full_carry |=> s_timeout_logged) // RULE17
        else $error("timeout not signalled");

endmodule

/* logic/bel_pkg.sv */
// Types of the bus error logger: status layout, error inputs, ratio.
// Assumes the widths written out here agree with bel_defs.svh.
package bel_pkg;

    // Validity indicators, bit 63 down to 57
    typedef struct packed {
        logic val;
        logic over;
        logic uc;
        logic en;
        logic miscv;
        logic addrv;
        logic pcc;
    } bel_valid_t;

    typedef struct packed {
        bel_valid_t valid;
        logic [9:0] corr_count;
        logic [2:0] rsvd_46_44;
        logic internal_flag;
        logic hard_flag;
        logic [2:0] rsvd_41_39;
        logic timeout_flag;
        logic [5:0] rsvd_37_32;
        logic [15:0] mse;
        logic [15:0] code;
    } bel_status_t;

    typedef struct packed {
        logic req_parity;
        logic resp_parity;
        logic data_parity;
        logic hard_resp;
        logic internal_fail;
        logic correctable;
    } bel_err_t;

    typedef enum logic [1:0] {
        BEL_RATIO_2,
        BEL_RATIO_3,
        BEL_RATIO_4,
        BEL_RATIO_4B
    } bel_ratio_t;

endpackage

/* tb/bel_bus_agent.sv */
// Far-side model: bus agents and chipset reporting error events.
// Assumes one clock shared with the logger; bench picks the event.
`timescale 1ns/1ps
module bel_bus_agent (
    // Clock
    input wire logic clk,
    // Command from the bench
    input wire logic fire,
    input wire logic [2:0] sel,
    // Event lines to the logger
    output bel_pkg::bel_err_t err
);
    // Registered so every report lasts exactly one cycle
    always @(posedge clk) begin
        if (fire && sel == 3'd6) begin
            // Request and data parity faults on one transfer
            err <= bel_pkg::bel_err_t'(6'h28);
        end else if (fire) begin
            err <= bel_pkg::bel_err_t'(6'h01 << sel);
        end else begin
            err <= '0;
        end
    end
endmodule

/* tb/bel_logger_tb_top.sv */
// Self-checking bench of the bus error logger.
// Assumes a bel_bus_agent at the event side and AXI4-Lite at registers.
`timescale 1ns/1ps
`include "bel_defs.svh"
module bel_logger_tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic int_pin, bus_init, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic retire = 1'b0, exc = 1'b0, fire = 1'b0;
    logic [2:0] sel = '0;
    bel_pkg::bel_err_t err_ev;
    int error_cnt = 0, comparisons = 0, pin_cnt = 0, init_cnt = 0;

    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (int_pin === 1'b1) pin_cnt++;
        if (bus_init === 1'b1) init_cnt++;
    end

    bel_bus_agent u_agent (.clk(clock), .fire(fire), .sel(sel),
        .err(err_ev));
    bel_logger u_dut (.CLOCK(clock), .RST_B(rst_b), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .INSTR_RETIRE(retire), .CORE_EXCEPTION(exc), .ERR_EVENTS(err_ev),
        .INTERNAL_FAILURE_PIN(int_pin), .BUS_INIT_EVENT(bus_init),
        .IRQ(irq));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Handshakes judged at the falling edge, acted on at the next rise
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        bit ha, hw, bv;
        int n;
        bv = 0;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bv && n < 100) begin
            @(negedge clock);
            ha = awvalid & awready;
            hw = wvalid & wready;
            bv = bvalid;
            r = bresp;
            @(posedge clock);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!bv) error_cnt++;
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        bit ha, rv;
        int n;
        rv = 0;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rv && n < 100) begin
            @(negedge clock);
            ha = arvalid & arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ha) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rv) error_cnt++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        check(d, exp);
    endtask

    task automatic fire_ev(input int k);
        @(posedge clock);
        sel <= 3'(k);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic clr();
        wr(`BEL_OFF_STAT_LO, 32'h0000_0000);
        wr(`BEL_OFF_STAT_HI, 32'h0000_0000);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rdchk(`BEL_OFF_STAT_LO, 32'h0000_0000);
        rdchk(`BEL_OFF_STAT_HI, 32'h0000_0000);
        rdchk(`BEL_OFF_IRQ_STAT, 32'h0000_0000);
        rdchk(`BEL_OFF_IRQ_MASK, 32'h0000_0000);
        rdchk(`BEL_OFF_CTRL, 32'h0000_0000);
        axr(12'h020, d, r);
        check({d, r}, {32'h0000_0000, `BEL_RESP_SLVERR});
        axw(12'h024, 32'h0000_FFFF, r);
        check(r, `BEL_RESP_SLVERR);
        $display("test reset done");
    endtask

    task automatic t_hard();
        rdchk(`BEL_OFF_STAT_LO, 32'h0000_0000);
        fire_ev(2);
        rdchk(`BEL_OFF_STAT_LO, 32'h0010_0E0F);
        rdchk(`BEL_OFF_STAT_HI, 32'hB000_0400);
        @(negedge clock);
        check(irq, 1'b0);
        wr(`BEL_OFF_IRQ_MASK, 32'h0000_0002);
        @(negedge clock);
        check(irq, 1'b1);
        fire_ev(5);
        rdchk(`BEL_OFF_STAT_LO, 32'h0010_0E0F);
        rdchk(`BEL_OFF_IRQ_STAT, 32'h0000_000A);
        wr(`BEL_OFF_IRQ_STAT, 32'h0000_0002);
        @(negedge clock);
        check(irq, 1'b0);
        rdchk(`BEL_OFF_IRQ_STAT, 32'h0000_0008);
        $display("test hard error done");
    endtask

    task automatic t_parity();
        int ks[4] = '{5, 4, 3, 6};
        logic [15:0] ms[4] = '{16'h0001, 16'h0020, 16'h0040, 16'h0041};
        for (int i = 0; i < 4; i++) begin
            clr();
            fire_ev(ks[i]);
            rdchk(`BEL_OFF_STAT_LO, {ms[i], 16'h0E0F});
        end
        clr();
        wr(`BEL_OFF_STAT_LO, 32'h0000_0E0F);
        wr(`BEL_OFF_STAT_LO, 32'hFFFF_0F0F);
        rdchk(`BEL_OFF_STAT_LO, 32'h0071_0E0F);
        $display("test parity done");
    endtask

    task automatic t_internal();
        logic [31:0] d;
        logic [1:0] r;
        int p0;
        clr();
        p0 = pin_cnt;
        fire_ev(1);
        check(pin_cnt - p0, 1);
        rdchk(`BEL_OFF_STAT_LO, 32'h0000_0400);
        axr(`BEL_OFF_STAT_HI, d, r);
        check({d[31], d[25], d[11]}, 3'b111);
        fire_ev(2);
        rdchk(`BEL_OFF_STAT_LO, 32'h0000_0400);
        $display("test internal done");
    endtask

    task automatic t_corr();
        logic [31:0] d;
        logic [1:0] r;
        clr();
        repeat (3) fire_ev(0);
        axr(`BEL_OFF_STAT_HI, d, r);
        check(d[24:15], 10'd3);
        $display("test correctable done");
    endtask

    // Prescaler phase is free-running, so one tick of slack is allowed
    task automatic t_wdog();
        logic [31:0] d;
        logic [1:0] r;
        int p;
        for (int k = 0; k < 3; k++) begin
            p = (k + 2) * 128;
            wr(`BEL_OFF_CTRL, 32'(k));
            retire <= 1'b1;
            @(posedge clock);
            retire <= 1'b0;
            axr(`BEL_OFF_WDOG, d, r);
            check(d <= 1, 1'b1);
            repeat (3 * p + p / 2) @(posedge clock);
            axr(`BEL_OFF_WDOG, d, r);
            check(d == 3 || d == 4, 1'b1);
            exc <= 1'b1;
            @(posedge clock);
            exc <= 1'b0;
            axr(`BEL_OFF_WDOG, d, r);
            check(d <= 1, 1'b1);
        end
        check(init_cnt, 0);
        $display("test watchdog done");
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #800000;
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_hard();
        t_parity();
        t_internal();
        t_corr();
        t_wdog();
        final_report();
    end
endmodule
